/* rtl/pma_reconfig_defines.vh */
// Constants for the analog control reconfiguration access block.
// Assumes byte addresses on an APB bus with 32-bit data.
`ifndef PMA_RECONFIG_DEFINES_VH
`define PMA_RECONFIG_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define PCR_CTRL_OFS     8'h00
`define PCR_WDATA_OFS    8'h04
`define PCR_STATUS_OFS   8'h08
`define PCR_RDSEL_OFS    8'h0C
`define PCR_RDATA_OFS    8'h10

// ==========================================================================
// Control register fields
`define PCR_CTRL_WR_BIT  0
`define PCR_CTRL_RD_BIT  1
`define PCR_CTRL_SEL_LO  2
`define PCR_CTRL_BC_BIT  4
`define PCR_CTRL_ADR_LO  8
`define PCR_SEL_TX_ONLY  2'b10
`define PCR_SEL_RX_ONLY  2'b01
`define PCR_SEL_RESET    2'b11

// ==========================================================================
// Setting fields, shared by write data and read data registers
`define PCR_VOD_LO       0
`define PCR_PRE_LO       8
`define PCR_DCG_LO       16
`define PCR_EQ_LO        24
`define PCR_VOD_W        3
`define PCR_PRE_W        5
`define PCR_DCG_W        2
`define PCR_EQ_W         4

// ==========================================================================
// Status register fields
`define PCR_ST_BUSY_BIT  0
`define PCR_ST_DV_BIT    1

// ==========================================================================
// Transaction lengths in clock cycles
`define PCR_WR_CYCLES    4
`define PCR_RD_CYCLES    4

`endif

/* rtl/pma_control_reconfig_access.v */
// Access path for analog transceiver settings (swing, pre-emphasis,
// DC gain, equalization), steered by software over APB.
// Assumes the channel setting registers and their readback run on pclk.
//
// Contract
// - Per-channel addressing exists only when more than one channel is served.
// - Per-channel mode uses 3, 5, 2 and 4 bit settings.
// - Portion select targets receiver only, transmitter only, or both.
// - Portion select 2'b10 restricts the transaction to transmit controls.
// - A one-cycle write strobe starts the write.
// - Busy is high while writing and falls when the write ends.
// - A one-cycle read strobe starts the read.
// - Busy high during a read; at the end busy falls, data-valid rises.
// - Write and read are never in progress together.
// - Broadcast writes the same settings into every channel.
// - Broadcast write settings are one 3, 5, 2, 4 bit set.
// - Broadcast readback is concatenated per channel, channel 0 lowest.
// - Channel address width follows the number of channels.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pma_reconfig_defines.vh"
`default_nettype none

module pma_control_reconfig_access #(
   parameter NUM_CH    = 4,
   parameter WR_CYCLES = `PCR_WR_CYCLES,
   parameter RD_CYCLES = `PCR_RD_CYCLES
) (
   // Clock and reset.
   input  wire                  pclk,
   input  wire                  presetn,
   // APB slave.
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [7:0]            paddr,
   input  wire [31:0]           pwdata,
   output reg  [31:0]           prdata,
   output reg                   pready,
   output reg                   pslverr,
   // Transaction status.
   output reg                   busy,
   output reg                   data_valid,
   // Write side toward the channel setting registers.
   output reg  [NUM_CH-1:0]     chan_wr_en,
   output reg                   chan_wr_tx,
   output reg                   chan_wr_rx,
   output reg  [3*NUM_CH-1:0]   chan_wr_vod,
   output reg  [5*NUM_CH-1:0]   chan_wr_preemp,
   output reg  [2*NUM_CH-1:0]   chan_wr_dcgain,
   output reg  [4*NUM_CH-1:0]   chan_wr_eq,
   // Current settings reported by the channels.
   input  wire [3*NUM_CH-1:0]   chan_rd_vod,
   input  wire [5*NUM_CH-1:0]   chan_rd_preemp,
   input  wire [2*NUM_CH-1:0]   chan_rd_dcgain,
   input  wire [4*NUM_CH-1:0]   chan_rd_eq,
   // Read results, concatenated per channel on broadcast, else one channel in the low field bits.
   output reg  [3*NUM_CH-1:0]   vod_out,
   output reg  [5*NUM_CH-1:0]   preemp_out,
   output reg  [2*NUM_CH-1:0]   dcgain_out,
   output reg  [4*NUM_CH-1:0]   eq_out
);

   // =======================================================================
   // Local constants
   // address width
   localparam AW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
   localparam [1:0] ST_IDLE  = 2'b00;
   localparam [1:0] ST_WRITE = 2'b01;
   localparam [1:0] ST_READ  = 2'b10;
   localparam integer WR_LAST_I = WR_CYCLES - 1;
   localparam integer RD_LAST_I = RD_CYCLES - 1;
   localparam [15:0] WR_LAST = WR_LAST_I[15:0];
   localparam [15:0] RD_LAST = RD_LAST_I[15:0];
   localparam SINGLE = (NUM_CH == 1) ? 1'b1 : 1'b0;

   // =======================================================================
   // Software visible state
   reg  [1:0]                   sel_r;
   reg                          bcast_r;
   reg  [AW-1:0]                addr_r;
   reg  [2:0]                   wvod_r;
   reg  [4:0]                   wpre_r;
   reg  [1:0]                   wdcg_r;
   reg  [3:0]                   weq_r;
   reg  [7:0]                   rdsel_r;

   // Transaction state, latched when a strobe is accepted.
   reg  [1:0]                   state_r;
   reg  [15:0]                  cnt_r;
   reg                          t_bcast_r;
   reg  [AW-1:0]                t_addr_r;
   reg                          t_tx_r;
   reg                          t_rx_r;

   // =======================================================================
   // Bus decode
   // The slave answers with one wait state, so pready is a plain flop.
   wire apb_done  = psel & penable & pready;
   wire apb_wr    = apb_done & pwrite;
   wire ctrl_wr   = apb_wr & (paddr == `PCR_CTRL_OFS);
   wire wdata_wr  = apb_wr & (paddr == `PCR_WDATA_OFS);
   wire rdsel_wr  = apb_wr & (paddr == `PCR_RDSEL_OFS);

   // Fields of a control write, used at once by its own strobes.
   wire [1:0]    new_sel   = pwdata[`PCR_CTRL_SEL_LO +: 2];
   wire          new_bc    = pwdata[`PCR_CTRL_BC_BIT] | SINGLE;
   wire [AW-1:0] new_addr  = pwdata[`PCR_CTRL_ADR_LO +: AW];
   wire          wr_stb    = pwdata[`PCR_CTRL_WR_BIT];
   wire          rd_stb    = pwdata[`PCR_CTRL_RD_BIT];
   // An address past the last channel would write nothing, so refuse it.
   wire          addr_ok   = new_bc | ({1'b0, new_addr} < NUM_CH);
   wire          idle      = (state_r == ST_IDLE);

   wire go_wr = ctrl_wr & wr_stb & ~rd_stb & idle & addr_ok;
   wire go_rd = ctrl_wr & rd_stb & ~wr_stb & idle & addr_ok;

   wire new_tx = (new_sel != `PCR_SEL_RX_ONLY);
   wire new_rx = (new_sel != `PCR_SEL_TX_ONLY);

   // =======================================================================
   // Channel target decode, one bit per channel
   wire [NUM_CH-1:0] hit;
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g = g + 1) begin : g_hit
         localparam integer CH_I = g;
         assign hit[g] = t_bcast_r | (t_addr_r == CH_I[AW-1:0]);
      end
   endgenerate

   // =======================================================================
   // Read capture
   // per-channel result sits in the low field bits
   reg [3*NUM_CH-1:0] cap_vod;
   reg [5*NUM_CH-1:0] cap_pre;
   reg [2*NUM_CH-1:0] cap_dcg;
   reg [4*NUM_CH-1:0] cap_eq;
   always @* begin
      cap_vod = {3*NUM_CH{1'b0}};
      cap_pre = {5*NUM_CH{1'b0}};
      cap_dcg = {2*NUM_CH{1'b0}};
      cap_eq  = {4*NUM_CH{1'b0}};
      if (t_bcast_r) begin
         cap_vod = chan_rd_vod;
         cap_pre = chan_rd_preemp;
         cap_dcg = chan_rd_dcgain;
         cap_eq  = chan_rd_eq;
      end else begin
         cap_vod[2:0] = chan_rd_vod[t_addr_r*3 +: 3];
         cap_pre[4:0] = chan_rd_preemp[t_addr_r*5 +: 5];
         cap_dcg[1:0] = chan_rd_dcgain[t_addr_r*2 +: 2];
         cap_eq[3:0]  = chan_rd_eq[t_addr_r*4 +: 4];
      end
      // The portion left out of the read reports zero.
      if (!t_tx_r) begin
         cap_vod = {3*NUM_CH{1'b0}};
         cap_pre = {5*NUM_CH{1'b0}};
      end
      if (!t_rx_r) begin
         cap_dcg = {2*NUM_CH{1'b0}};
         cap_eq  = {4*NUM_CH{1'b0}};
      end
   end

   // =======================================================================
   // Read data mux
   // Readback of one channel slice chosen by the readback index.
   wire [7:0]  rd_i   = rdsel_r;
   wire [31:0] rslice = {4'h0, eq_out[rd_i*4 +: 4], 6'h00,
                         dcgain_out[rd_i*2 +: 2], 3'h0,
                         preemp_out[rd_i*5 +: 5], 5'h00,
                         vod_out[rd_i*3 +: 3]};
   reg  [31:0] rdata_nxt;
   reg         hit_nxt;
   always @* begin
      rdata_nxt = 32'h0000_0000;
      hit_nxt   = 1'b1;
      case (paddr)
         `PCR_CTRL_OFS: begin
            rdata_nxt[`PCR_CTRL_SEL_LO +: 2]  = sel_r;
            rdata_nxt[`PCR_CTRL_BC_BIT]       = bcast_r;
            rdata_nxt[`PCR_CTRL_ADR_LO +: AW] = addr_r;
         end
         `PCR_WDATA_OFS: begin
            rdata_nxt[`PCR_VOD_LO +: `PCR_VOD_W] = wvod_r;
            rdata_nxt[`PCR_PRE_LO +: `PCR_PRE_W] = wpre_r;
            rdata_nxt[`PCR_DCG_LO +: `PCR_DCG_W] = wdcg_r;
            rdata_nxt[`PCR_EQ_LO  +: `PCR_EQ_W]  = weq_r;
         end
         `PCR_STATUS_OFS: begin
            rdata_nxt[`PCR_ST_BUSY_BIT] = busy;
            rdata_nxt[`PCR_ST_DV_BIT]   = data_valid;
         end
         `PCR_RDSEL_OFS: begin
            rdata_nxt[7:0] = rdsel_r;
         end
         `PCR_RDATA_OFS: begin
            if (rdsel_r < NUM_CH)
               rdata_nxt = rslice;
         end
         default: begin
            hit_nxt = 1'b0;
         end
      endcase
   end

   // =======================================================================
   // APB answer
   // One wait state keeps prdata and pslverr registered outputs.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         if (psel & penable & ~pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
            pslverr <= ~hit_nxt;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // =======================================================================
   // Software registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_r   <= `PCR_SEL_RESET;
         bcast_r <= 1'b0;
         addr_r  <= {AW{1'b0}};
         wvod_r  <= 3'h0;
         wpre_r  <= 5'h00;
         wdcg_r  <= 2'h0;
         weq_r   <= 4'h0;
         rdsel_r <= 8'h00;
      end else begin
         if (ctrl_wr) begin
            sel_r   <= new_sel;
            bcast_r <= new_bc;
            addr_r  <= new_addr;
         end
         // one settings set for all channels
         if (wdata_wr) begin
            wvod_r <= pwdata[`PCR_VOD_LO +: `PCR_VOD_W];
            wpre_r <= pwdata[`PCR_PRE_LO +: `PCR_PRE_W];
            wdcg_r <= pwdata[`PCR_DCG_LO +: `PCR_DCG_W];
            weq_r  <= pwdata[`PCR_EQ_LO  +: `PCR_EQ_W];
         end
         if (rdsel_wr)
            rdsel_r <= pwdata[7:0];
      end
   end

   // =======================================================================
   // Transaction sequencer
   // Settings are latched at the strobe, so a careless host cannot change
   // the value that lands in the channel halfway through a write.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r        <= ST_IDLE;
         cnt_r          <= 16'h0000;
         busy           <= 1'b0;
         data_valid     <= 1'b0;
         t_bcast_r      <= 1'b0;
         t_addr_r       <= {AW{1'b0}};
         t_tx_r         <= 1'b0;
         t_rx_r         <= 1'b0;
         chan_wr_en     <= {NUM_CH{1'b0}};
         chan_wr_tx     <= 1'b0;
         chan_wr_rx     <= 1'b0;
         chan_wr_vod    <= {3*NUM_CH{1'b0}};
         chan_wr_preemp <= {5*NUM_CH{1'b0}};
         chan_wr_dcgain <= {2*NUM_CH{1'b0}};
         chan_wr_eq     <= {4*NUM_CH{1'b0}};
         vod_out        <= {3*NUM_CH{1'b0}};
         preemp_out     <= {5*NUM_CH{1'b0}};
         dcgain_out     <= {2*NUM_CH{1'b0}};
         eq_out         <= {4*NUM_CH{1'b0}};
      end else begin
         chan_wr_en <= {NUM_CH{1'b0}};
         case (state_r)
            ST_IDLE: begin
               if (go_wr | go_rd) begin
                  t_bcast_r  <= new_bc;
                  t_addr_r   <= new_addr;
                  t_tx_r     <= new_tx;
                  t_rx_r     <= new_rx;
                  busy       <= 1'b1;
                  data_valid <= 1'b0;
               end
               if (go_wr) begin
                  state_r        <= ST_WRITE;
                  cnt_r          <= WR_LAST;
                  chan_wr_tx     <= new_tx;
                  chan_wr_rx     <= new_rx;
                  chan_wr_vod    <= {NUM_CH{wvod_r}};
                  chan_wr_preemp <= {NUM_CH{wpre_r}};
                  chan_wr_dcgain <= {NUM_CH{wdcg_r}};
                  chan_wr_eq     <= {NUM_CH{weq_r}};
               end
               if (go_rd) begin
                  state_r <= ST_READ;
                  cnt_r   <= RD_LAST;
               end
            end
            ST_WRITE: begin
               if (cnt_r == 16'h0000) begin
                  chan_wr_en <= hit;
                  busy       <= 1'b0;
                  state_r    <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            ST_READ: begin
               if (cnt_r == 16'h0000) begin
                  vod_out    <= cap_vod;
                  preemp_out <= cap_pre;
                  dcgain_out <= cap_dcg;
                  eq_out     <= cap_eq;
                  busy       <= 1'b0;
                  data_valid <= 1'b1;
                  state_r    <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               busy    <= 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

/* test/pma_reconfig_monitor.sv */
// Checker for the analog setting access block, bound to its top module.
// Assumes one pclk domain and the reset released by presetn going high.
`timescale 1ns/1ps
`default_nettype none
module pma_reconfig_monitor #(
   parameter NUM_CH    = 4,
   parameter WR_CYCLES = 4,
   parameter RD_CYCLES = 4
) (
   // Clock and reset.
   input wire logic                pclk,
   input wire logic                presetn,
   // Status and channel write side.
   input wire logic                busy,
   input wire logic                data_valid,
   input wire logic [NUM_CH-1:0]   chan_wr_en,
   input wire logic                chan_wr_tx,
   input wire logic                chan_wr_rx,
   input wire logic [3*NUM_CH-1:0] chan_wr_vod,
   input wire logic [4*NUM_CH-1:0] chan_wr_eq,
   // Read results.
   input wire logic [3*NUM_CH-1:0] vod_out,
   input wire logic [4*NUM_CH-1:0] eq_out
);
   localparam int MAXC = (WR_CYCLES > RD_CYCLES) ? WR_CYCLES : RD_CYCLES;
   logic [7:0] busy_len_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ======================================================================
   // Busy length counter; cleared while idle so each transaction restarts.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_len_r <= 8'h00;
      end else begin
         busy_len_r <= busy ? busy_len_r + 8'h01 : 8'h00;
      end
   end

   // ======================================================================
   // Transaction properties.
   a_write_length: assert property (
      $fell(busy) && chan_wr_en != 0 |-> busy_len_r == WR_CYCLES)
      else $error("write busy length wrong");
   a_read_length: assert property (
      $rose(data_valid) |-> $fell(busy) && busy_len_r == RD_CYCLES)
      else $error("read completion timing wrong");
   a_wren_at_end: assert property (
      chan_wr_en != 0 |-> $fell(busy) && !data_valid)
      else $error("channel write outside write completion");
   a_wren_pulse: assert property (
      chan_wr_en != 0 |=> chan_wr_en == 0)
      else $error("channel write enable longer than one cycle");
   a_valid_idle: assert property (
      data_valid |-> !busy) else $error("data valid while busy");
   a_valid_clear: assert property (
      $fell(data_valid) |-> $rose(busy))
      else $error("data valid dropped without new transaction");
   a_no_restart: assert property (
      busy_len_r <= MAXC) else $error("busy held too long");
   a_one_target: assert property (
      chan_wr_en != 0 |-> $onehot(chan_wr_en) || &chan_wr_en)
      else $error("channel write hits a wrong set");
   a_bcast_same: assert property (
      &chan_wr_en |-> chan_wr_vod == {NUM_CH{chan_wr_vod[2:0]}}
      && chan_wr_eq == {NUM_CH{chan_wr_eq[3:0]}})
      else $error("broadcast settings differ between channels");
   a_portion_set: assert property (
      chan_wr_en != 0 |-> chan_wr_tx || chan_wr_rx)
      else $error("channel write with no portion");
   a_out_hold: assert property (
      !$rose(data_valid) |-> $stable(vod_out) && $stable(eq_out))
      else $error("read results changed outside completion");

   // Main scenarios reached.
   c_bcast_write: cover property (&chan_wr_en);
   c_chan_write: cover property ($onehot(chan_wr_en));
   c_read_done: cover property ($rose(data_valid));
endmodule

bind pma_control_reconfig_access pma_reconfig_monitor #(
   .NUM_CH(NUM_CH), .WR_CYCLES(WR_CYCLES), .RD_CYCLES(RD_CYCLES)
) i_pma_reconfig_monitor (
   .pclk(pclk), .presetn(presetn), .busy(busy), .data_valid(data_valid),
   .chan_wr_en(chan_wr_en), .chan_wr_tx(chan_wr_tx),
   .chan_wr_rx(chan_wr_rx), .chan_wr_vod(chan_wr_vod),
   .chan_wr_eq(chan_wr_eq), .vod_out(vod_out), .eq_out(eq_out)
);
`default_nettype wire

/* test/pma_channel_model.sv */
// Model of the channels' analog setting registers on the far side.
// Assumes write enables and settings come on pclk from the access block.
`timescale 1ns/1ps
`default_nettype none
module pma_channel_model #(
   parameter NUM_CH = 4
) (
   // Clock and reset.
   input  wire logic                pclk,
   input  wire logic                presetn,
   // Writes from the access block.
   input  wire logic [NUM_CH-1:0]   wr_en,
   input  wire logic                wr_tx,
   input  wire logic                wr_rx,
   input  wire logic [3*NUM_CH-1:0] wr_vod,
   input  wire logic [5*NUM_CH-1:0] wr_pre,
   input  wire logic [2*NUM_CH-1:0] wr_dcg,
   input  wire logic [4*NUM_CH-1:0] wr_eq,
   // Current settings.
   output logic      [3*NUM_CH-1:0] rd_vod,
   output logic      [5*NUM_CH-1:0] rd_pre,
   output logic      [2*NUM_CH-1:0] rd_dcg,
   output logic      [4*NUM_CH-1:0] rd_eq
);
   // ======================================================================
   // Storage; each portion updates only when selected, so a stray portion
   // bit in the block shows up as a changed setting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_vod <= '0;
         rd_pre <= '0;
         rd_dcg <= '0;
         rd_eq  <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (wr_en[i] && wr_tx) begin
               rd_vod[3*i +: 3] <= wr_vod[3*i +: 3];
               rd_pre[5*i +: 5] <= wr_pre[5*i +: 5];
            end
            if (wr_en[i] && wr_rx) begin
               rd_dcg[2*i +: 2] <= wr_dcg[2*i +: 2];
               rd_eq[4*i +: 4]  <= wr_eq[4*i +: 4];
            end
         end
      end
   end
endmodule
`default_nettype wire

/* test/tb.sv */
// Testbench: APB register tasks drive transactions into the access block.
// Assumes the block's register map constants from the shared defines file.
`timescale 1ns/1ps
`include "pma_reconfig_defines.vh"
`default_nettype none
module tb;
   localparam int N = 4;
   localparam int WRC = 8;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic busy, data_valid, wtx, wrx;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic [N-1:0] wen;
   logic [3*N-1:0] wv, rv, vo;
   logic [5*N-1:0] wp, rp, po;
   logic [2*N-1:0] wd, rg, go;
   logic [4*N-1:0] we, re, eo;
   logic [2:0] ev [N];
   logic [4:0] ep [N];
   logic [1:0] ed [N];
   logic [3:0] ee [N];
   int mismatches, checks_done, cyc;

   pma_control_reconfig_access #(.NUM_CH(N), .WR_CYCLES(WRC), .RD_CYCLES(4))
   i_pma_control_reconfig_access (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .busy(busy),
      .data_valid(data_valid), .chan_wr_en(wen), .chan_wr_tx(wtx),
      .chan_wr_rx(wrx), .chan_wr_vod(wv), .chan_wr_preemp(wp),
      .chan_wr_dcgain(wd), .chan_wr_eq(we), .chan_rd_vod(rv),
      .chan_rd_preemp(rp), .chan_rd_dcgain(rg), .chan_rd_eq(re),
      .vod_out(vo), .preemp_out(po), .dcgain_out(go), .eq_out(eo));

   pma_channel_model #(.NUM_CH(N)) i_pma_channel_model (
      .pclk(pclk), .presetn(presetn), .wr_en(wen), .wr_tx(wtx),
      .wr_rx(wrx), .wr_vod(wv), .wr_pre(wp), .wr_dcg(wd), .wr_eq(we),
      .rd_vod(rv), .rd_pre(rp), .rd_dcg(rg), .rd_eq(re));

   // ======================================================================
   // Clock, and a cycle ceiling far above the few hundred cycles needed.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen at an edge.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wdat);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wdat;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         apb(1'b0, `PCR_STATUS_OFS, 32'h0);
         k++;
      end while (rd[0] !== 1'b0 && k < 20);
   endtask

   // Start a transaction, wait for it, then compare the channels or the
   // read results with what the portion and mode select imply.
   task automatic xact(input logic rdop, input logic [1:0] sel,
                       input logic bc, input logic [1:0] ch);
      int j;
      logic tx, rx;
      apb(1'b1, `PCR_WDATA_OFS, d);
      wait_idle();
      apb(1'b1, `PCR_CTRL_OFS, {22'h0, ch, 3'h0, bc, sel, rdop, ~rdop});
      wait_idle();
      for (int i = 0; i < N; i++) begin
         j = bc ? i : ch;
         tx = (sel != 2'b01) && (bc || i == 0 || !rdop);
         rx = (sel != 2'b10) && (bc || i == 0 || !rdop);
         if (!rdop && (bc || i == ch)) begin
            if (tx) {ev[i], ep[i]} = {d[2:0], d[12:8]};
            if (rx) {ed[i], ee[i]} = {d[17:16], d[27:24]};
         end
         if (!rdop) chk({rv[3*i+:3], rp[5*i+:5], rg[2*i+:2], re[4*i+:4]}, {ev[i], ep[i], ed[i], ee[i]});
         else chk({vo[3*i+:3], po[5*i+:5], go[2*i+:2], eo[4*i+:4]}, {tx ? {ev[j], ep[j]} : 8'h00, rx ? {ed[j], ee[j]} : 6'h00});
      end
      chk({busy, data_valid}, {1'b0, rdop});
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ======================================================================
   // Main sequence.
   initial begin
      {psel, penable, pwrite, paddr, pwdata, d} = '0;
      {mismatches, checks_done, cyc} = '0;
      for (int i = 0; i < N; i++) {ev[i], ep[i], ed[i], ee[i]} = 14'h0;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `PCR_STATUS_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk(err, 1'b1);
      $display("test reset done");
      // Every portion code, broadcast write then broadcast read.
      for (int k = 0; k < 4; k++) begin
         d = {4'h0, 4'(k + 3), 6'h0, 2'(k), 3'h0, 5'(k * 7 + 1), 5'h0,
              3'(k + 1)};
         xact(1'b0, 2'(k), 1'b1, 2'h0);
         xact(1'b1, 2'(k), 1'b1, 2'h0);
      end
      apb(1'b1, `PCR_RDSEL_OFS, 32'h1);
      apb(1'b0, `PCR_RDATA_OFS, 32'h0);
      chk(rd, {4'h0, ee[1], 6'h0, ed[1], 3'h0, ep[1], 5'h0, ev[1]});
      $display("test broadcast done");
      // Per-channel transmit-only write, then reads of one channel.
      d = 32'h0C011E05;
      xact(1'b0, `PCR_SEL_TX_ONLY, 1'b0, 2'h2);
      xact(1'b1, 2'b11, 1'b0, 2'h2);
      xact(1'b1, `PCR_SEL_TX_ONLY, 1'b0, 2'h3);
      $display("test channel done");
      // A read strobe while a write runs, and both strobes at once.
      d = 32'h05020A07;
      apb(1'b1, `PCR_WDATA_OFS, d);
      apb(1'b1, `PCR_CTRL_OFS, 32'h0000001D);
      apb(1'b1, `PCR_CTRL_OFS, 32'h0000001E);
      wait_idle();
      chk(rd, 32'h0);
      chk(rv, {N{d[2:0]}});
      apb(1'b1, `PCR_CTRL_OFS, 32'h0000001F);
      repeat (3) @(posedge pclk);
      chk(busy, 1'b0);
      $display("test collision done");
      test_done();
   end
endmodule
`default_nettype wire
